// ===== snc_regs.svh
`ifndef SNC_REGS_SVH
`define SNC_REGS_SVH

// register offsets on the serial register port
`define SNC_ADDR_CONFIG 8'h09
`define SNC_ADDR_CTRL 8'h0a

// reset values
`define SNC_CONFIG_RST 8'h00
`define SNC_CTRL_RST 8'h00

// snapshot_config fields
`define SNC_CFG_FRAMES_MSB 7
`define SNC_CFG_FRAMES_LSB 6
`define SNC_CFG_SHUTTER 5
`define SNC_CFG_SYNC_POL 4
`define SNC_CFG_LEVEL_MODE 2
`define SNC_CFG_EDGE_SEL 1
`define SNC_CFG_INT_POL 0
// reserved bit 3 reads as zero
`define SNC_CFG_WMASK 8'hf7

// snapshot_control_status fields
`define SNC_CTL_INT_EN 7
`define SNC_CTL_TRIG_FLAG 6
`define SNC_CTL_DONE_FLAG 5
`define SNC_CTL_HOST_MODE 4
`define SNC_CTL_SYNC 3
`define SNC_CTL_BUSY 2
`define SNC_CTL_SOFT_TRIG 1
`define SNC_CTL_GO 0

// exposure frame counter
`define SNC_CNT_ZERO 2'h0
`define SNC_CNT_ONE 2'h1

`endif

// ===== snc_pkg.sv
package snc_pkg;

    typedef enum logic [1:0] {
        SNC_IDLE,
        SNC_ALIGN,
        SNC_EXPOSE,
        SNC_READOUT
    } snc_state_t;

    typedef struct packed {
        snc_state_t state;
        logic [1:0] frame_cnt;
        logic [7:0] config_reg;
        logic int_en;
        logic host_mode;
        logic go;
        logic [7:0] rdata;
    } snc_ctrl_t;

    typedef struct packed {
        logic prev;
        logic primed;
    } snc_trig_t;

    typedef struct packed {
        logic trig_flag;
        logic done_flag;
        logic irq;
    } snc_irq_t;

endpackage

// ===== snc_trig_det.sv
`timescale 1ns/1ps
module snc_trig_det
    import snc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic pin_i,
    input wire logic soft_i,
    input wire logic edge_sel_i,
    input wire logic level_mode_i,
    output logic event_o,
    output logic active_o
);

    snc_trig_t s_q;
    snc_trig_t s_d;
    logic edge_hit;

    always_comb
    begin
        s_d = s_q;
        s_d.prev = pin_i;
        s_d.primed = 1'b1;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // R6: edge select
    assign active_o = edge_sel_i ? pin_i : ~pin_i;
    // no edge before the first sample, avoids a false edge out of reset
    assign edge_hit = s_q.primed & (edge_sel_i ? (pin_i & ~s_q.prev) : (~pin_i & s_q.prev));
    // R15: soft trigger acts as a pin event
    assign event_o = (level_mode_i ? active_o : edge_hit) | soft_i;

endmodule

// ===== snc_irq_gen.sv
`timescale 1ns/1ps
module snc_irq_gen
    import snc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic int_en_i,
    input wire logic polarity_i,
    input wire logic set_trig_i,
    input wire logic set_done_i,
    input wire logic clear_i,
    output logic trig_flag_o,
    output logic done_flag_o,
    output logic irq_o
);

    snc_irq_t s_q;
    snc_irq_t s_d;

    always_comb
    begin
        s_d = s_q;
        // R8: causes gated by enable
        // R9: clear on read, a new event wins
        s_d.trig_flag = (s_q.trig_flag & ~clear_i) | (set_trig_i & int_en_i);
        // R10: clear on read, a new event wins
        s_d.done_flag = (s_q.done_flag & ~clear_i) | (set_done_i & int_en_i);
        // R17: level while enabled and a cause pending
        s_d.irq = (int_en_i & (s_d.trig_flag | s_d.done_flag)) ^ polarity_i;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign trig_flag_o = s_q.trig_flag;
    assign done_flag_o = s_q.done_flag;
    // R7: polarity applied before the register, so irq_o follows a polarity change one cycle later
    assign irq_o = s_q.irq;

endmodule

// ===== snc_snapshot_ctrl.sv
`timescale 1ns/1ps
`include "snc_regs.svh"
// Behaviour
// R1: without shutter, wait frames_before_readout code plus one frames.
// R2: external_shutter_select chooses shutter or shutterless sequence.
// R3: shutter_sync_polarity set makes sync output active low.
// R4: trigger_level_mode set repeats sequences while trigger stays active. The code does not repeat in host-controlled mode.
// R5: trigger_level_mode clear runs one sequence per trigger pulse.
// R6: trigger_edge_select set means rising edge, clear means falling.
// R7: int_output_polarity set makes interrupt output active low.
// R8: no snapshot interrupt unless capture_int_enable is set.
// R9: trigger_cause_flag marks trigger interrupts, cleared by reading.
// R10: readout_done_flag marks readout completion, cleared by reading.
// R11: host-controlled mode: trigger only interrupts, host starts with go.
// R12: automatic mode starts the sequence at once on a trigger.
// R13: sync_required_status mirrors the sync output event.
// R14: readout_busy_status reads 1 throughout snapshot readout.
// R15: soft_trigger write acts like a trigger pin event.
// R16: host_capture_go launches a sequence in host-controlled mode.
// R17: interrupt active while enabled and any cause flag set.
// R18: triggers arriving during a sequence are dropped, not queued.
module snc_snapshot_ctrl
    import snc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic trigger_i,
    input wire logic frame_start_i,
    output logic ext_sync_o,
    output logic readout_busy_o,
    output logic irq_o
);

    snc_ctrl_t s_q;
    snc_ctrl_t s_d;

    logic wr_cfg;
    logic wr_ctl;
    logic rd_ctl;
    logic soft_trig;
    logic trig_evt;
    logic trig_active;
    logic trig_flag;
    logic done_flag;
    logic start_seq;
    logic accept_trig;
    logic seq_done;
    logic sync_int;
    logic busy_int;
    logic [1:0] frames_target;

    logic cfg_shutter;
    logic cfg_sync_pol;
    logic cfg_level;
    logic cfg_edge;
    logic cfg_int_pol;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    assign wr_cfg = reg_wr_i & hit(reg_addr_i, `SNC_ADDR_CONFIG);
    assign wr_ctl = reg_wr_i & hit(reg_addr_i, `SNC_ADDR_CTRL);
    assign rd_ctl = reg_rd_i & hit(reg_addr_i, `SNC_ADDR_CTRL);
    // R15: write-one pulse, never stored
    assign soft_trig = wr_ctl & reg_wdata_i[`SNC_CTL_SOFT_TRIG];

    assign cfg_shutter = s_q.config_reg[`SNC_CFG_SHUTTER];
    assign cfg_sync_pol = s_q.config_reg[`SNC_CFG_SYNC_POL];
    assign cfg_level = s_q.config_reg[`SNC_CFG_LEVEL_MODE];
    assign cfg_edge = s_q.config_reg[`SNC_CFG_EDGE_SEL];
    assign cfg_int_pol = s_q.config_reg[`SNC_CFG_INT_POL];

    snc_trig_det u_trig (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(trigger_i),
        .soft_i(soft_trig),
        .edge_sel_i(cfg_edge),
        .level_mode_i(cfg_level),
        .event_o(trig_evt),
        .active_o(trig_active)
    );

    // R18: only an idle controller takes a trigger
    assign accept_trig = trig_evt & (s_q.state == SNC_IDLE);
    // R12: automatic start on trigger
    // R11: host mode waits for go
    // R16: go launches from idle in host mode
    assign start_seq = (s_q.state == SNC_IDLE) &
                       (s_q.host_mode ? s_q.go : trig_evt);

    // R1: shutterless wait is code plus one frames
    // R2: shutter sequence exposes for one frame only
    assign frames_target = cfg_shutter ? `SNC_CNT_ZERO :
                           s_q.config_reg[`SNC_CFG_FRAMES_MSB:`SNC_CFG_FRAMES_LSB];

    assign seq_done = (s_q.state == SNC_READOUT) & frame_start_i;
    // R13: sync event during exposure
    assign sync_int = (s_q.state == SNC_EXPOSE);
    // R14: busy through readout
    assign busy_int = (s_q.state == SNC_READOUT);

    snc_irq_gen u_irq (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .int_en_i(s_q.int_en),
        .polarity_i(cfg_int_pol),
        .set_trig_i(accept_trig),
        .set_done_i(seq_done),
        .clear_i(rd_ctl),
        .trig_flag_o(trig_flag),
        .done_flag_o(done_flag),
        .irq_o(irq_o)
    );

    always_comb
    begin
        s_d = s_q;
        if (wr_cfg)
        begin
            s_d.config_reg = reg_wdata_i & `SNC_CFG_WMASK;
        end
        if (wr_ctl)
        begin
            s_d.int_en = reg_wdata_i[`SNC_CTL_INT_EN];
            s_d.host_mode = reg_wdata_i[`SNC_CTL_HOST_MODE];
            s_d.go = reg_wdata_i[`SNC_CTL_GO];
        end
        unique case (s_q.state)
            SNC_IDLE:
            begin
                if (start_seq)
                begin
                    s_d.state = SNC_ALIGN;
                    s_d.go = 1'b0;
                end
            end
            // exposure starts on a frame boundary
            SNC_ALIGN:
            begin
                if (frame_start_i)
                begin
                    s_d.state = SNC_EXPOSE;
                    s_d.frame_cnt = `SNC_CNT_ZERO;
                end
            end
            SNC_EXPOSE:
            begin
                if (frame_start_i)
                begin
                    if (s_q.frame_cnt == frames_target)
                    begin
                        s_d.state = SNC_READOUT;
                    end
                    else
                    begin
                        s_d.frame_cnt = s_q.frame_cnt + `SNC_CNT_ONE;
                    end
                end
            end
            SNC_READOUT:
            begin
                if (frame_start_i)
                begin
                    // R4: back to back in automatic mode while the pin holds its level
                    // R5: pulse mode ends after one sequence
                    if (cfg_level & trig_active & ~s_q.host_mode)
                    begin
                        s_d.state = SNC_EXPOSE;
                        s_d.frame_cnt = `SNC_CNT_ZERO;
                    end
                    else
                    begin
                        s_d.state = SNC_IDLE;
                    end
                end
            end
        endcase
        s_d.rdata = 8'h00;
        if (reg_rd_i & hit(reg_addr_i, `SNC_ADDR_CONFIG))
        begin
            s_d.rdata = s_q.config_reg;
        end
        else if (rd_ctl)
        begin
            s_d.rdata[`SNC_CTL_INT_EN] = s_q.int_en;
            s_d.rdata[`SNC_CTL_TRIG_FLAG] = trig_flag;
            s_d.rdata[`SNC_CTL_DONE_FLAG] = done_flag;
            s_d.rdata[`SNC_CTL_HOST_MODE] = s_q.host_mode;
            s_d.rdata[`SNC_CTL_SYNC] = sync_int;
            s_d.rdata[`SNC_CTL_BUSY] = busy_int;
            s_d.rdata[`SNC_CTL_GO] = s_q.go;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            s_q.state <= SNC_IDLE;
            s_q.frame_cnt <= `SNC_CNT_ZERO;
            s_q.config_reg <= `SNC_CONFIG_RST;
            s_q.int_en <= 1'b0;
            s_q.host_mode <= 1'b0;
            s_q.go <= 1'b0;
            s_q.rdata <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o = s_q.rdata;
    // R3: sync pin polarity
    assign ext_sync_o = sync_int ^ cfg_sync_pol;
    assign readout_busy_o = busy_int;

    // checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    frames_wait_a: assert property ( // R1
        (s_q.state == SNC_EXPOSE && frame_start_i && !cfg_shutter &&
         s_q.frame_cnt == s_q.config_reg[`SNC_CFG_FRAMES_MSB:`SNC_CFG_FRAMES_LSB])
        |=> s_q.state == SNC_READOUT)
        else $error("shutterless readout not reached after programmed frames");

    shutter_expose_a: assert property ( // R2
        (s_q.state == SNC_EXPOSE && frame_start_i && cfg_shutter)
        |=> s_q.state == SNC_READOUT)
        else $error("shutter sequence exposed longer than one frame");

    sync_polarity_a: assert property ( // R3
        ext_sync_o == ((s_q.state == SNC_EXPOSE) != cfg_sync_pol))
        else $error("sync output level wrong");

    level_repeat_a: assert property ( // R4
        (seq_done && cfg_level && trig_active && !s_q.host_mode)
        |=> s_q.state == SNC_EXPOSE && s_q.frame_cnt == `SNC_CNT_ZERO)
        else $error("level mode failed to repeat");

    pulse_single_a: assert property ( // R5
        (seq_done && !cfg_level) |=> s_q.state == SNC_IDLE)
        else $error("pulse mode ran a second sequence");

    irq_level_a: assert property ( // R7
        irq_o == (($past(s_q.int_en) && (trig_flag || done_flag)) != $past(cfg_int_pol)))
        else $error("interrupt level wrong");

    int_disabled_a: assert property ( // R8
        (!s_q.int_en && !trig_flag && !done_flag) |=> !trig_flag && !done_flag)
        else $error("flag set while interrupt disabled");

    trig_clear_a: assert property ( // R9
        (rd_ctl && !accept_trig) |=> !trig_flag)
        else $error("trigger flag survived read");

    done_set_a: assert property ( // R10
        (seq_done && s_q.int_en) |=> done_flag)
        else $error("done flag not set after readout");

    host_wait_a: assert property ( // R11
        (s_q.state == SNC_IDLE && s_q.host_mode && !s_q.go) |=> s_q.state == SNC_IDLE)
        else $error("host mode started without go");

    auto_start_a: assert property ( // R12
        (s_q.state == SNC_IDLE && !s_q.host_mode && trig_evt) |=> s_q.state == SNC_ALIGN)
        else $error("automatic start missed");

    busy_status_a: assert property ( // R14
        (s_q.state == SNC_EXPOSE && frame_start_i &&
         s_q.frame_cnt == frames_target) |=> readout_busy_o)
        else $error("busy missing during readout");

    busy_ignore_a: assert property ( // R18
        (s_q.state == SNC_READOUT && !frame_start_i) |=> s_q.state == SNC_READOUT)
        else $error("trigger disturbed a running readout");

    go_launch_a: assert property ( // R16
        (s_q.state == SNC_IDLE && s_q.host_mode && s_q.go) |=> s_q.state == SNC_ALIGN && !s_q.go)
        else $error("go did not launch sequence");

    trig_set_a: assert property ( // R9
        (accept_trig && s_q.int_en) |=> trig_flag)
        else $error("trigger flag not set on accepted trigger");

    done_clear_a: assert property ( // R10
        (rd_ctl && !seq_done) |=> !done_flag)
        else $error("done flag survived read");

    edge_event_a: assert property ( // R6
        (trig_evt && !cfg_level && !soft_trig)
        |-> (cfg_edge ? (trigger_i && !$past(trigger_i)) : (!trigger_i && $past(trigger_i))))
        else $error("trigger event on the wrong pin edge");

    soft_start_a: assert property ( // R15
        (soft_trig && s_q.state == SNC_IDLE && !s_q.host_mode) |=> s_q.state == SNC_ALIGN)
        else $error("soft trigger did not start a sequence");

    cfg_readback_a: assert property ( // R2
        (reg_rd_i && hit(reg_addr_i, `SNC_ADDR_CONFIG))
        |=> reg_rdata_o == $past(s_q.config_reg))
        else $error("configuration read back wrong");

    sync_status_a: assert property ( // R13
        rd_ctl |=> reg_rdata_o[`SNC_CTL_SYNC] == $past(ext_sync_o != cfg_sync_pol))
        else $error("sync status does not mirror the sync pin");

    busy_read_a: assert property ( // R14
        rd_ctl |=> reg_rdata_o[`SNC_CTL_BUSY] == $past(readout_busy_o))
        else $error("busy status does not mirror readout");

    readout_end_a: assert property ( // R14
        (seq_done && !(cfg_level && trig_active && !s_q.host_mode)) |=> !readout_busy_o)
        else $error("busy stayed high after readout");

    trig_drop_a: assert property ( // R18
        (s_q.state != SNC_IDLE && trig_evt && !trig_flag) |=> !trig_flag)
        else $error("trigger during a sequence raised a flag");

    irq_active_a: assert property ( // R17
        (s_q.int_en && (trig_flag || done_flag) && !rd_ctl && !wr_ctl && !wr_cfg)
        |=> irq_o != cfg_int_pol)
        else $error("interrupt not active with a cause pending");

    host_flag_a: assert property ( // R11
        (s_q.state == SNC_IDLE && s_q.host_mode && !s_q.go && trig_evt && s_q.int_en)
        |=> trig_flag && s_q.state == SNC_IDLE)
        else $error("host mode trigger did not only flag");

    cover_auto_seq: cover property (
        s_q.state == SNC_IDLE && trig_evt && !s_q.host_mode ##[1:200] seq_done);
    cover_host_seq: cover property (
        s_q.state == SNC_IDLE && s_q.host_mode && s_q.go ##[1:200] seq_done);
    cover_level_rpt: cover property (
        seq_done && cfg_level && trig_active ##1 s_q.state == SNC_EXPOSE);
    cover_irq_clear: cover property (done_flag ##1 rd_ctl ##1 !done_flag);

endmodule

// ===== snc_frame_src.sv
`timescale 1ns/1ps
module snc_frame_src #(
    parameter int PERIOD = 24
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    output logic frame_start_o
);
    int cnt;
    // free running, so a trigger may land anywhere inside a frame
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i || cnt == PERIOD - 1)
            cnt <= 0;
        else
            cnt <= cnt + 1;
        frame_start_o <= !sys_rst_i && cnt == PERIOD - 1;
    end
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`include "snc_regs.svh"
module tb_top;
    localparam int PER = 24;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic trig = 1'b1;
    logic [7:0] rdata;
    logic fs, sync, busy, irq;
    logic sync_act = 1'b1;
    logic irq_act = 1'b1;
    logic [7:0] exp_q[$];
    logic [7:0] lfsr = 8'h62;
    int sync_cnt;
    int bad_count = 0;
    int checks = 0;

    snc_snapshot_ctrl u_dut (
        .sys_clk_i(clk),
        .sys_rst_i(rst),
        .reg_addr_i(addr),
        .reg_wr_i(wr),
        .reg_rd_i(rd),
        .reg_wdata_i(wdata),
        .reg_rdata_o(rdata),
        .trigger_i(trig),
        .frame_start_i(fs),
        .ext_sync_o(sync),
        .readout_busy_o(busy),
        .irq_o(irq)
    );

    snc_frame_src #(.PERIOD(PER)) u_src (
        .sys_clk_i(clk),
        .sys_rst_i(rst),
        .frame_start_o(fs)
    );

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic [7:0] next_rand(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic complete_run();
        if (bad_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp(logic [7:0] got, logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pins(logic [2:0] exp);
        @(negedge clk);
        cmp({5'h00, sync, busy, irq}, {5'h00, exp});
        @(posedge clk);
    endtask

    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
        exp_q.push_back(exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    // read data stands one cycle, so it is taken at the middle of it
    always @(posedge clk)
        rd_d <= rd;
    always @(negedge clk)
        if (rd_d)
            cmp(rdata, exp_q.pop_front());

    task automatic pulse();
        trig <= ~trig;
        @(posedge clk);
        trig <= ~trig;
        @(posedge clk);
    endtask

    // bounded wait on busy, counting frame boundaries and sync cycles
    task automatic wait_busy(logic v, output int n);
        n = 0;
        for (int i = 0; i < 400; i++)
        begin
            @(negedge clk);
            if (busy === v)
                break;
            n += (fs === 1'b1);
            sync_cnt += (sync === sync_act);
        end
        if (busy !== v)
        begin
            bad_count++;
            complete_run();
        end
        @(posedge clk);
    endtask

    task automatic quiet(int cyc);
        int n = 0;
        repeat (cyc)
        begin
            @(negedge clk);
            n += (busy !== 1'b0 || sync !== ~sync_act);
        end
        cmp(8'(n), 8'h00);
        @(posedge clk);
    endtask

    task automatic shot(int nf, logic en, logic [7:0] st);
        int n;
        sync_cnt = 0;
        wait_busy(1'b1, n);
        cmp(8'(n), 8'(nf + 1));
        cmp(8'(sync_cnt), 8'(nf * PER));
        wait_busy(1'b0, n);
        cmp(8'(n), 8'h01);
        repeat (2) @(posedge clk);
        chk_pins({~sync_act, 1'b0, en ? irq_act : ~irq_act});
        rd_reg(`SNC_ADDR_CTRL, st);
        chk_pins({~sync_act, 1'b0, ~irq_act});
    endtask

    initial
    begin
        int n;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(`SNC_ADDR_CONFIG, `SNC_CONFIG_RST);
        rd_reg(`SNC_ADDR_CTRL, `SNC_CTRL_RST);
        chk_pins(3'b000);
        // level mode kept off here: the pin idles at its active level
        for (int i = 0; i < 4; i++)
        begin
            lfsr = next_rand(lfsr);
            wr_reg(`SNC_ADDR_CONFIG, lfsr & 8'hfb);
            rd_reg(`SNC_ADDR_CONFIG, lfsr & 8'hfb & `SNC_CFG_WMASK);
            wr_reg(lfsr | 8'h80, 8'hff);
            rd_reg(lfsr | 8'h80, 8'h00);
        end
        wr_reg(`SNC_ADDR_CONFIG, 8'h00);
        wr_reg(`SNC_ADDR_CTRL, 8'h80);
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(`SNC_ADDR_CONFIG, 8'(i << 6));
            pulse();
            shot(i + 1, 1'b1, 8'he0);
        end
        wr_reg(`SNC_ADDR_CONFIG, 8'hf3);
        trig <= 1'b0;
        sync_act = 1'b0;
        irq_act = 1'b0;
        quiet(4);
        pulse();
        shot(1, 1'b1, 8'he0);
        wr_reg(`SNC_ADDR_CONFIG, 8'h00);
        trig <= 1'b1;
        sync_act = 1'b1;
        irq_act = 1'b1;
        wr_reg(`SNC_ADDR_CTRL, 8'h00);
        wr_reg(`SNC_ADDR_CTRL, 8'h02);
        wait_busy(1'b1, n);
        cmp(8'(n), 8'h02);
        wr_reg(`SNC_ADDR_CTRL, 8'h02);
        wait_busy(1'b0, n);
        quiet(4 * PER);
        chk_pins(3'b000);
        rd_reg(`SNC_ADDR_CTRL, 8'h00);
        wr_reg(`SNC_ADDR_CTRL, 8'h90);
        pulse();
        quiet(4 * PER);
        rd_reg(`SNC_ADDR_CTRL, 8'hd0);
        // the host launches the held sequence itself
        wr_reg(`SNC_ADDR_CTRL, 8'h91);
        shot(1, 1'b1, 8'hb0);
        wr_reg(`SNC_ADDR_CTRL, 8'h00);
        wr_reg(`SNC_ADDR_CONFIG, 8'h04);
        trig <= 1'b0;
        wait_busy(1'b1, n);
        cmp(8'(n), 8'h02);
        wait_busy(1'b0, n);
        rd_reg(`SNC_ADDR_CTRL, 8'h08);
        wait_busy(1'b1, n);
        cmp(8'(n), 8'h01);
        trig <= 1'b1;
        wait_busy(1'b0, n);
        quiet(4 * PER);
        complete_run();
    end
endmodule
